// *** fsoc_top.sv ***
// flash security and option control with an AHB-Lite register slave
// assumes stored option byte and key are stable while reset is held
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
// How it works
// - options register is loaded from the stored option byte at reset
// - options bits 5..2 read zero; writes ignored; always readable
// - backdoor enable zero refuses every key unlock attempt
// - matching eight ascending key bytes unlock security until reset
// - key bytes from background debug commands never unlock
// - options bit 6 one disables vector redirection
// - security code 1 0 alone means unsecured
// - while secure, debug access requests are not granted
// - key unlock or full blank check forces security code to 1 0
// - config bits 4..0 read zero and ignore writes
// - key select clear: key window writes start a command
// - key select set: key window writes are captured as key bytes
// - clearing key select after eight writes ends and checks the key
// - memory clock is bus clock, optionally over eight, over div+1
module fsoc_top
  import fsoc_pkg::*;
#(
  parameter int unsigned DIV_W = 6
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // nonvolatile contents
  input wire logic [7:0] stored_option_byte_i,
  input wire logic [63:0] stored_compare_key_i,
  input wire logic blank_check_pass_i,
  // memory write path from the core or debug port
  input wire fsoc_pkg::fsoc_mem_wr_s mem_wr_i,
  input wire logic debug_access_req_i,
  // results
  output fsoc_pkg::fsoc_opt_s option_o,
  output logic debug_access_grant_o,
  output logic cmd_start_o,
  output logic [15:0] cmd_addr_o,
  output logic [7:0] cmd_data_o,
  output logic mem_clk_tick_o
);
  initial
  begin
    if (DIV_W != 6)
      $error("divisor field is six bits wide");
  end

  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [13:0] idx);
    reg_hit = (a[31:16] == 16'h0000) && (a[15:2] == idx);
  endfunction

  function automatic logic in_key_window(input logic [15:0] a);
    in_key_window = (a[15:3] == KEY_BASE[15:3]);
  endfunction

  // ----------------------------------------------------------------
  // bus interface state
  // ----------------------------------------------------------------
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic [31:0] addr_q, addr_d;
  logic hreadyout_q, hreadyout_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hresp_q;
  logic addr_ok;

  // ----------------------------------------------------------------
  // register and key state
  // ----------------------------------------------------------------
  logic [7:0] opt_q, opt_d;
  logic [7:0] cfg_q, cfg_d;
  logic [6:0] div_q, div_d;
  logic div_loaded_q, div_loaded_d;
  logic unlock_q, unlock_d;
  logic [63:0] key_q, key_d;
  logic [3:0] key_cnt_q, key_cnt_d;
  logic key_bad_q, key_bad_d;
  fsoc_opt_s out_q, out_d;
  logic grant_q, grant_d;
  logic cmd_q, cmd_d;
  logic [15:0] cmd_addr_q, cmd_addr_d;
  logic [7:0] cmd_data_q, cmd_data_d;
  logic tick_q;
  logic tick;
  logic bus_wr;
  logic keysel_fall;
  logic key_wr;
  logic [1:0] sec_eff;
  logic [10:0] pulse_cyc;
  logic pulse_ok;
  logic [7:0] status;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign addr_ok = hsel_i && hready_i && htrans_i[1];

  always_comb
  begin
    wr_pend_d = 1'b0;
    rd_pend_d = rd_pend_q;
    addr_d = addr_q;
    hreadyout_d = hreadyout_q;
    hrdata_d = hrdata_q;
    if (rd_pend_q)
    begin
      hrdata_d = 32'h0;
      if (reg_hit(addr_q, IDX_OPTION))
        hrdata_d[7:0] = {opt_q[7:2], sec_eff} & OPT_READ_MASK;
      else if (reg_hit(addr_q, IDX_KEY_CONFIG))
        hrdata_d[7:0] = cfg_q & CFG_READ_MASK;
      else if (reg_hit(addr_q, IDX_CLK_DIV))
        hrdata_d[7:0] = {div_loaded_q, div_q};
      else if (reg_hit(addr_q, IDX_KEY_STATUS))
        hrdata_d[7:0] = status;
      rd_pend_d = 1'b0;
      hreadyout_d = 1'b1;
    end
    if (addr_ok)
    begin
      addr_d = haddr_i;
      wr_pend_d = hwrite_i;
      if (!hwrite_i)
      begin
        rd_pend_d = 1'b1;
        hreadyout_d = 1'b0;
      end
    end
  end

  assign bus_wr = wr_pend_q;

  // ----------------------------------------------------------------
  // derived values
  // ----------------------------------------------------------------
  assign sec_eff = unlock_q ? SEC_UNSECURED : opt_q[OPT_SEC_LSB +: 2];
  assign pulse_cyc = div_q[DIV_PRESCALE_BIT] ?
    {{2'b00, div_q[5:0]} + 8'h01, 3'b000} :
    {5'h00, div_q[5:0]} + 11'h001;
  assign pulse_ok = div_loaded_q &&
    ({21'h0, pulse_cyc} >= 32'(PULSE_MIN_CYC)) &&
    ({21'h0, pulse_cyc} <= 32'(PULSE_MAX_CYC));
  assign status = {3'b000, key_bad_q, key_cnt_q[3], unlock_q, pulse_ok,
                   sec_eff != SEC_UNSECURED};
  assign keysel_fall = bus_wr && reg_hit(addr_q, IDX_KEY_CONFIG) &&
    cfg_q[CFG_KEYSEL_BIT] && !hwdata_i[CFG_KEYSEL_BIT];
  assign key_wr = mem_wr_i.valid && in_key_window(mem_wr_i.addr) &&
    cfg_q[CFG_KEYSEL_BIT];

  // ----------------------------------------------------------------
  // registers, key capture and security
  // ----------------------------------------------------------------
  always_comb
  begin
    opt_d = opt_q;
    cfg_d = cfg_q;
    div_d = div_q;
    div_loaded_d = div_loaded_q;
    unlock_d = unlock_q;
    key_d = key_q;
    key_cnt_d = key_cnt_q;
    key_bad_d = key_bad_q;
    cmd_d = 1'b0;
    cmd_addr_d = cmd_addr_q;
    cmd_data_d = cmd_data_q;
    if (bus_wr && reg_hit(addr_q, IDX_KEY_CONFIG))
      cfg_d = hwdata_i[7:0] & CFG_WRITE_MASK;
    if (bus_wr && reg_hit(addr_q, IDX_CLK_DIV) && !div_loaded_q)
    begin
      div_d = hwdata_i[6:0];
      div_loaded_d = 1'b1;
    end
    if (key_wr)
    begin
      if (mem_wr_i.from_debug)
        key_bad_d = 1'b1;
      else if (key_cnt_q < 4'(KEY_BYTES) &&
               mem_wr_i.addr[2:0] == key_cnt_q[2:0])
      begin
        key_d[{key_cnt_q[2:0], 3'b000} +: 8] = mem_wr_i.data;
        key_cnt_d = key_cnt_q + 4'h1;
      end
      else
        key_bad_d = 1'b1;
    end
    else if (mem_wr_i.valid && in_key_window(mem_wr_i.addr))
    begin
      cmd_d = 1'b1;
      cmd_addr_d = mem_wr_i.addr;
      cmd_data_d = mem_wr_i.data;
    end
    if (keysel_fall)
    begin
      if (opt_q[OPT_BACKDOOR_BIT] && !key_bad_q &&
          key_cnt_q == 4'(KEY_BYTES) &&
          key_q == stored_compare_key_i)
        unlock_d = 1'b1;
      key_cnt_d = 4'h0;
      key_bad_d = 1'b0;
    end
    if (blank_check_pass_i)
      unlock_d = 1'b1;
  end

  always_comb
  begin
    out_d.backdoor_enable = opt_q[OPT_BACKDOOR_BIT];
    out_d.vector_redirect_disable = opt_q[OPT_REDIRECT_BIT];
    out_d.security_code = sec_eff;
    out_d.secure = (sec_eff != SEC_UNSECURED);
    grant_d = debug_access_req_i && (sec_eff == SEC_UNSECURED);
  end

  fsoc_clk_div #(
    .DIV_W(DIV_W)
  ) u_clk_div (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .enable_i(div_loaded_q),
    .prescale_i(div_q[DIV_PRESCALE_BIT]),
    .divisor_i(div_q[5:0]),
    .tick_o(tick)
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 32'h0;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0;
      hresp_q <= 1'b0;
      opt_q <= stored_option_byte_i & OPT_READ_MASK;
      cfg_q <= CFG_RESET;
      div_q <= DIV_RESET;
      div_loaded_q <= 1'b0;
      unlock_q <= 1'b0;
      key_q <= 64'h0;
      key_cnt_q <= 4'h0;
      key_bad_q <= 1'b0;
      out_q <= '0;
      grant_q <= 1'b0;
      cmd_q <= 1'b0;
      cmd_addr_q <= 16'h0;
      cmd_data_q <= 8'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q <= addr_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q <= hrdata_d;
      hresp_q <= 1'b0;
      opt_q <= opt_d;
      cfg_q <= cfg_d;
      div_q <= div_d;
      div_loaded_q <= div_loaded_d;
      unlock_q <= unlock_d;
      key_q <= key_d;
      key_cnt_q <= key_cnt_d;
      key_bad_q <= key_bad_d;
      out_q <= out_d;
      grant_q <= grant_d;
      cmd_q <= cmd_d;
      cmd_addr_q <= cmd_addr_d;
      cmd_data_q <= cmd_data_d;
      tick_q <= tick;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout_o = hreadyout_q;
  assign hresp_o = hresp_q;
  assign hrdata_o = hrdata_q;
  assign option_o = out_q;
  assign debug_access_grant_o = grant_q;
  assign cmd_start_o = cmd_q;
  assign cmd_addr_o = cmd_addr_q;
  assign cmd_data_o = cmd_data_q;
  assign mem_clk_tick_o = tick_q;
endmodule

// *** fsoc_pkg.sv ***
// constants, field layouts and carrier types for the flash security block
// assumes a 125 MHz bus clock and word-indexed register addressing
package fsoc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_CLK_DIV = 14'h1820;
  localparam logic [13:0] IDX_OPTION = 14'h1821;
  localparam logic [13:0] IDX_KEY_CONFIG = 14'h1823;
  localparam logic [13:0] IDX_KEY_STATUS = 14'h1830;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned OPT_BACKDOOR_BIT = 7;
  localparam int unsigned OPT_REDIRECT_BIT = 6;
  localparam int unsigned OPT_SEC_LSB = 0;
  localparam logic [7:0] OPT_READ_MASK = 8'hc3;
  localparam int unsigned CFG_KEYSEL_BIT = 5;
  localparam logic [7:0] CFG_WRITE_MASK = 8'he0;
  localparam logic [7:0] CFG_READ_MASK = 8'h60;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int unsigned DIV_LOADED_BIT = 7;
  localparam int unsigned DIV_PRESCALE_BIT = 6;
  localparam logic [6:0] DIV_RESET = 7'h00;
  localparam logic [1:0] SEC_UNSECURED = 2'b10;

  // ----------------------------------------------------------------
  // key window
  // ----------------------------------------------------------------
  localparam logic [15:0] KEY_BASE = 16'hffb0;
  localparam int unsigned KEY_BYTES = 8;
  localparam int unsigned PRESCALE_RATIO = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned PULSE_MIN_NS = 5000;
  localparam int unsigned PULSE_MAX_PS = 6700000;
  localparam int unsigned PULSE_MIN_CYC =
    (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_PS / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
    logic from_debug;
  } fsoc_mem_wr_s;

  typedef struct packed {
    logic backdoor_enable;
    logic vector_redirect_disable;
    logic secure;
    logic [1:0] security_code;
  } fsoc_opt_s;

endpackage

// *** fsoc_clk_div.sv ***
// memory clock divider: bus clock, optional divide by eight, then div+1
// assumes divisor settings are stable once loaded
`timescale 1ns/10ps
module fsoc_clk_div
  import fsoc_pkg::*;
#(
  parameter int unsigned DIV_W = 6
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // settings
  input wire logic enable_i,
  input wire logic prescale_i,
  input wire logic [DIV_W-1:0] divisor_i,
  // one bus-cycle pulse per memory clock period
  output logic tick_o
);
  initial
  begin
    if (DIV_W < 1 || DIV_W > 16)
      $error("divisor width out of range");
  end

  logic [2:0] pre_q, pre_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic pre_tick;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  always_comb
  begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    pre_tick = 1'b1;
    if (enable_i)
    begin
      if (prescale_i)
      begin
        pre_d = pre_q + 3'h1;
        pre_tick = (pre_q == 3'(PRESCALE_RATIO - 1));
      end
      if (pre_tick)
      begin
        if (cnt_q >= divisor_i)
        begin
          cnt_d = '0;
          tick_d = 1'b1;
        end
        else
          cnt_d = cnt_q + 1'b1;
      end
    end
    else
    begin
      pre_d = 3'h0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pre_q <= 3'h0;
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule

// *** fsoc_top_chk_asserts.sv ***
// port checker for the flash security block
// assumes bind into fsoc_top, one clock, synchronous reset
`timescale 1ns/10ps
module fsoc_top_chk
  import fsoc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // bus
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  // memory side
  input wire logic blank_check_pass_i,
  input wire fsoc_pkg::fsoc_mem_wr_s mem_wr_i,
  input wire logic debug_access_req_i,
  input wire fsoc_pkg::fsoc_opt_s option_o,
  input wire logic debug_access_grant_o,
  input wire logic cmd_start_o,
  input wire logic [15:0] cmd_addr_o,
  input wire logic [7:0] cmd_data_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // edges since reset release, saturating
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic rd_go, wr_go, unl;
  always_comb up_d = (up_q == 2'd3) ? up_q : up_q + 2'd1;
  always_ff @(posedge clk_sys_i) up_q <= rst_n_i ? up_d : 2'd0;
  assign rd_go = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign wr_go = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  assign unl = option_o.security_code == SEC_UNSECURED;
  AST_SEC_DECODE: assert property (
    up_q == 2'd3 |-> option_o.secure == !unl)
    else $error("secure flag disagrees with code");
  AST_GRANT: assert property (
    up_q == 2'd3 |->
    debug_access_grant_o == ($past(debug_access_req_i) && unl))
    else $error("grant wrong for security state");
  AST_OPT_STABLE: assert property (
    up_q == 2'd3 |-> $stable(option_o.backdoor_enable) &&
    $stable(option_o.vector_redirect_disable))
    else $error("option bits changed without reset");
  AST_BLANK_UNLOCK: assert property (
    blank_check_pass_i |-> ##2 unl)
    else $error("blank check did not unlock");
  AST_NOKEY_LOCKED: assert property (
    up_q == 2'd3 && !option_o.backdoor_enable && unl && !$past(unl)
    |-> $past(blank_check_pass_i, 2))
    else $error("unlock with backdoor disabled");
  AST_UNLOCK_HOLD: assert property (
    up_q == 2'd3 && $past(unl) |-> unl)
    else $error("unlock lost before reset");
  AST_READ_WAIT: assert property (
    rd_go |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read answer timing wrong");
  AST_WRITE_ZW: assert property (
    wr_go |=> hreadyout_o)
    else $error("write stalled");
  AST_CMD_ECHO: assert property (
    cmd_start_o |-> $past(mem_wr_i.valid) &&
    {cmd_addr_o, cmd_data_o} == $past({mem_wr_i.addr, mem_wr_i.data}))
    else $error("command start without matching write");
  cover property (rd_go);
  cover property (cmd_start_o);
  cover property (unl && !$past(unl));
endmodule
bind fsoc_top fsoc_top_chk u_fsoc_top_chk (
  .clk_sys_i, .rst_n_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
  .hreadyout_o, .blank_check_pass_i, .mem_wr_i, .debug_access_req_i,
  .option_o, .debug_access_grant_o, .cmd_start_o, .cmd_addr_o,
  .cmd_data_o);

// *** fsoc_core_mdl.sv ***
// core and debug write source model for the key window
// assumes go_i is a one-cycle pulse while busy_o is low
`timescale 1ns/10ps
module fsoc_core_mdl
  import fsoc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // burst request
  input wire logic go_i,
  input wire logic dbg_i,
  input wire logic slow_i,
  input wire logic [15:0] base_i,
  input wire logic [3:0] n_i,
  input wire logic [63:0] key_i,
  // memory write port
  output fsoc_pkg::fsoc_mem_wr_s mem_wr_o,
  output logic busy_o
);
  logic [3:0] idx;
  logic [1:0] gap;
  always @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      busy_o <= 1'b0;
      idx <= 4'd0;
      gap <= 2'd0;
      mem_wr_o <= '0;
    end
    else if (busy_o && !go_i && gap == 2'd0)
    begin
      // ascending bytes, user or debug source
      mem_wr_o <= '{1'b1, base_i + 16'(idx), key_i[8*idx +: 8],
                    dbg_i};
      idx <= idx + 4'd1;
      gap <= slow_i ? 2'd3 : 2'd0;
      busy_o <= (idx + 4'd1 != n_i);
    end
    else
    begin
      // idle: strobe low, released lines show the inverse
      mem_wr_o.valid <= 1'b0;
      mem_wr_o.addr <= ~mem_wr_o.addr;
      mem_wr_o.data <= ~mem_wr_o.data;
      if (go_i)
      begin
        busy_o <= 1'b1;
        idx <= 4'd0;
        gap <= 2'd0;
      end
      else if (busy_o)
        gap <= gap - 2'd1;
    end
  end
endmodule

// *** tb_flash_security_option_control.sv ***
// self-checking bench for the flash security block
// assumes fsoc_top, the core model and the bound checker
`timescale 1ns/10ps
module tb_flash_security_option_control;
  import fsoc_pkg::*;
  localparam logic [31:0] A_DIV = {16'h0, IDX_CLK_DIV, 2'b00};
  localparam logic [31:0] A_OPT = {16'h0, IDX_OPTION, 2'b00};
  localparam logic [31:0] A_CFG = {16'h0, IDX_KEY_CONFIG, 2'b00};
  localparam logic [31:0] A_STS = {16'h0, IDX_KEY_STATUS, 2'b00};
  logic clk_sys_i = 0, rst_n_i = 0, hsel = 0, hwrite = 0, hrdy, hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [7:0] opt_in = 0, cmd_data;
  logic [63:0] key = 0, mkey = 0;
  logic blank = 0, dreq = 0, grant, cmd_start, tick, go = 0, dbg = 0;
  logic slow = 0, busy;
  logic [15:0] base = 0, cmd_addr;
  logic [3:0] n = 0;
  fsoc_mem_wr_s mem_wr;
  fsoc_opt_s option;
  int err_count = 0, n_compared = 0, cyc = 0, n_cmd = 0, per = 0, gap_c = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  fsoc_top u_fsoc_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .stored_option_byte_i(opt_in), .stored_compare_key_i(key),
    .blank_check_pass_i(blank), .mem_wr_i(mem_wr),
    .debug_access_req_i(dreq), .option_o(option),
    .debug_access_grant_o(grant), .cmd_start_o(cmd_start),
    .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data), .mem_clk_tick_o(tick));
  fsoc_core_mdl u_fsoc_core_mdl (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .go_i(go), .dbg_i(dbg), .slow_i(slow),
    .base_i(base), .n_i(n), .key_i(mkey), .mem_wr_o(mem_wr),
    .busy_o(busy));
  always @(posedge clk_sys_i)
  begin
    n_cmd <= n_cmd + int'(cmd_start);
    per <= tick ? gap_c + 1 : per;
    gap_c <= tick ? 0 : gap_c + 1;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      end_of_test;
    end
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic chk_opt(input logic [7:0] e);
    rd(A_OPT, {24'h0, e});
    chk(32'(option), 32'({e[7:6], e[1:0] != SEC_UNSECURED, e[1:0]}));
  endtask
  task automatic send(input logic [15:0] b, input logic [3:0] k,
                      input logic d, s, input logic [63:0] v);
    @(posedge clk_sys_i);
    go <= 1'b1;
    base <= b;
    n <= k;
    dbg <= d;
    slow <= s;
    mkey <= v;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do @(posedge clk_sys_i); while (busy);
    repeat (3) @(posedge clk_sys_i);
  endtask
  initial
  begin
    logic [63:0] kst;
    logic [7:0] opt, e;
    logic [1:0] sec;
    logic [5:0] d;
    int c, k, pc;
    void'($urandom(32'h4def45a2));
    kst = {$urandom, $urandom};
    for (int p = 0; p < 4; p++)
    begin
      sec = 2'($urandom_range(0, 2));
      if (sec == 2'd2) sec = 2'd3;
      if (p == 2) sec = SEC_UNSECURED;
      opt = {p != 1, 1'($urandom), 4'($urandom), sec};
      e = opt & OPT_READ_MASK;
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      opt_in <= opt;
      key <= kst;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk_opt(e);
      wr(A_OPT, 32'hff);
      chk_opt(e);
      wr(A_CFG, 32'hff);
      rd(A_CFG, {24'h0, CFG_READ_MASK});
      wr(A_CFG, 32'h0);
      rd(32'h6100, 32'h0);
      k = $urandom_range(0, 7);
      c = n_cmd;
      send(KEY_BASE + 16'(k), 4'd1, 1'b0, 1'b0, kst);
      chk(n_cmd, c + 1);
      chk({cmd_addr, cmd_data}, {KEY_BASE + 16'(k), kst[7:0]});
      @(posedge clk_sys_i) dreq <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk(grant, sec == SEC_UNSECURED);
      dreq <= 1'b0;
      for (int j = 0; j < 3; j++)
      begin
        wr(A_CFG, 32'h20);
        c = n_cmd;
        send(KEY_BASE, 4'd8, j == 0, j == 0, j == 1 ? ~kst : kst);
        chk(n_cmd, c);
        wr(A_CFG, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        if (j == 2 && opt[7]) e[1:0] = SEC_UNSECURED;
        chk_opt(e);
      end
      @(posedge clk_sys_i) blank <= 1'b1;
      @(posedge clk_sys_i) blank <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      e[1:0] = SEC_UNSECURED;
      chk_opt(e);
      d = (p == 2) ? 6'd39 : 6'($urandom_range(0, 3));
      pc = (d + 1) * (p[0] ? 8 : 1);
      wr(A_DIV, {25'h0, p[0], d});
      wr(A_DIV, 32'h3f);
      repeat (3) do @(posedge clk_sys_i); while (tick !== 1'b1);
      #1;
      chk(per, pc);
      rd(A_STS, {29'h1, pc >= PULSE_MIN_CYC && pc <= PULSE_MAX_CYC,
        1'b0});
    end
    end_of_test;
  end
endmodule
